// ---- pkg/mmtr_pkg.sv ----
// Package for the multi-mode timing relay block
// Assumes a 50 MHz system clock and APB register access
package mmtr_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] CTRL_OFFS = 8'h00;
  localparam logic [7:0] SP1_OFFS = 8'h04;
  localparam logic [7:0] SP2_OFFS = 8'h08;
  localparam logic [7:0] STAT_OFFS = 8'h0C;
  localparam logic [7:0] ELAP_OFFS = 8'h10;
  localparam logic [7:0] COIL_OFFS = 8'h14;
  // Control fields
  localparam int MODE_LSB = 0;
  localparam int RAND_BIT = 4;
  localparam int RETAIN_BIT = 5;
  localparam int ENABLE_BIT = 6;
  // Coil register fields
  localparam int TRIG_BIT = 0;
  localparam int HOLD_BIT = 1;
  localparam int CLR_BIT = 2;
  // Reset values
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [16:0] SP_RST = 17'h00000;
  localparam logic [16:0] LFSR_SEED = 17'h1ACE5;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ = 50000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [16:0] SP_MAX = 17'h1869F;
  typedef enum logic [2:0] {
    MMTR_ON_DELAY,
    MMTR_OFF_DELAY,
    MMTR_ON_OFF,
    MMTR_PULSE,
    MMTR_FLASH
  } mmtr_mode_t;
  typedef enum logic [1:0] {
    MMTR_IDLE,
    MMTR_PICKUP,
    MMTR_CLOSED,
    MMTR_DROPOUT
  } mmtr_state_t;
endpackage

// ---- verilog/mmtr_relay.sv ----
// Multi-mode timing relay with APB register access
// Assumes coil pins come from another domain; ms tick derived from clk
// What this block does
// - On-delay closes after trigger held full setpoint
// - On-delay trigger drop discards elapsed time
// - On-delay hold freezes elapsed, then resumes
// - Hold ignored once on-delay contact closed
// - Clear opens contact, zeroes time, every mode
// - Clear release with trigger high restarts timing
// - Off-delay: closed with trigger, times after fall
// - Off-delay hold suspends run-down, contact stays
// - Off-delay retrigger clears elapsed time
// - Off-delay clear opens contact immediately
// - Combined: first pick-up, second drop-out
// - Combined hold pauses running delay only
// - Random mode switches within setpoint range
// - Pulse edge closes contact for setpoint time
// - Pulse opens at expiry despite long trigger
// - Pulse hold pauses timing, contact held
// - Pulse restarts if clear released, trigger high
// - Flash alternates pulse closed, pause open
// - Flash allows equal or unequal times
// - Flash hold freezes; clear ends flashing
// - Retentive elapsed time survives stop
// - Flash sequence starts with pulse phase
// - Setpoints 0 to 99999 ms, 1 ms steps
// - Oversized setpoint clamped to maximum
`timescale 1ns/100ps
module mmtr_relay (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Coil pins from ladder logic
  input wire logic triggerCoil,
  input wire logic holdCoil,
  input wire logic clearCoil,
  // Make contact
  output logic contact
);
  // ************************************************************
  // Registers
  // ************************************************************
  logic [6:0] ctrl_r;
  logic [16:0] firstSetpoint_r;
  logic [16:0] secondSetpoint_r;
  logic [2:0] swCoil_r;
  logic [1:0] trigSync_r, holdSync_r, clrSync_r;
  logic trigPrev_r, clrPrev_r;
  logic [15:0] tickCnt_r;
  logic tick_r;
  logic [16:0] elapsed_r;
  logic [16:0] target_r;
  logic [16:0] lfsr_r;
  logic contact_r;
  logic phasePulse_r;
  mmtr_pkg::mmtr_state_t state_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // Clamp a setpoint to the millisecond range 0..SP_MAX
  function automatic logic [16:0] clampSp(input logic [31:0] v);
    clampSp = (v > {15'h0000, mmtr_pkg::SP_MAX}) ? mmtr_pkg::SP_MAX : v[16:0];
  endfunction

  // Random draw uniform in 0..sp
  function automatic logic [16:0] randBelow(input logic [16:0] sp, input logic [16:0] rnd);
    logic [33:0] prod;
    prod = 34'(sp + 17'h00001) * 34'(rnd);
    randBelow = prod[33:17];
  endfunction

  // ************************************************************
  // Input sync and tick
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trigSync_r <= 2'h0;
      holdSync_r <= 2'h0;
      clrSync_r <= 2'h0;
    end
    else
    begin
      trigSync_r <= {trigSync_r[0], triggerCoil};
      holdSync_r <= {holdSync_r[0], holdCoil};
      clrSync_r <= {clrSync_r[0], clearCoil};
    end
  end

  logic trig, hold, clr, mode_en, randOn, retain;
  mmtr_pkg::mmtr_mode_t mode;
  assign trig = trigSync_r[1] | swCoil_r[mmtr_pkg::TRIG_BIT];
  assign hold = holdSync_r[1] | swCoil_r[mmtr_pkg::HOLD_BIT];
  assign clr = clrSync_r[1] | swCoil_r[mmtr_pkg::CLR_BIT];
  assign mode = mmtr_pkg::mmtr_mode_t'(ctrl_r[mmtr_pkg::MODE_LSB +: 3]);
  assign randOn = ctrl_r[mmtr_pkg::RAND_BIT];
  assign retain = ctrl_r[mmtr_pkg::RETAIN_BIT];
  assign mode_en = ctrl_r[mmtr_pkg::ENABLE_BIT];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tickCnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (tickCnt_r == 16'(mmtr_pkg::TICK_CYCLES - 1))
    begin
      tickCnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end
    else
    begin
      tickCnt_r <= tickCnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lfsr_r <= mmtr_pkg::LFSR_SEED;
    else
      lfsr_r <= {lfsr_r[15:0], lfsr_r[16] ^ lfsr_r[13]};
  end

  // ************************************************************
  // Timing engine
  // ************************************************************
  logic trigRise, trigFall, clrFall, done;
  logic [16:0] sp1, sp2;
  assign trigRise = trig & ~trigPrev_r;
  assign trigFall = ~trig & trigPrev_r;
  assign clrFall = ~clr & clrPrev_r;
  // Hold freezes completion too, so a held zero-length delay cannot expire
  assign done = (elapsed_r >= target_r) && !hold;
  assign sp1 = randOn ? randBelow(firstSetpoint_r, lfsr_r) : firstSetpoint_r;
  assign sp2 = randOn ? randBelow(secondSetpoint_r, lfsr_r) : secondSetpoint_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trigPrev_r <= 1'b0;
      clrPrev_r <= 1'b0;
    end
    else
    begin
      trigPrev_r <= trig;
      clrPrev_r <= clr;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= mmtr_pkg::MMTR_IDLE;
      elapsed_r <= 17'h00000;
      target_r <= 17'h00000;
      contact_r <= 1'b0;
      phasePulse_r <= 1'b0;
    end
    else if (!mode_en)
    begin
      // Stop: a retentive relay keeps its elapsed time
      state_r <= mmtr_pkg::MMTR_IDLE;
      contact_r <= 1'b0;
      if (!retain)
        elapsed_r <= 17'h00000;
    end
    else if (clr)
    begin
      state_r <= mmtr_pkg::MMTR_IDLE;
      elapsed_r <= 17'h00000;
      contact_r <= 1'b0;
      phasePulse_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        mmtr_pkg::MMTR_IDLE:
        begin
          contact_r <= 1'b0;
          // Start on edge, on clear release, or when retentive, with trigger high
          if (trig && (trigRise || clrFall || retain))
          begin
            case (mode)
              mmtr_pkg::MMTR_OFF_DELAY:
              begin
                state_r <= mmtr_pkg::MMTR_CLOSED;
                contact_r <= 1'b1;
              end
              mmtr_pkg::MMTR_PULSE:
              begin
                state_r <= mmtr_pkg::MMTR_PICKUP;
                target_r <= firstSetpoint_r;
                contact_r <= 1'b1;
              end
              mmtr_pkg::MMTR_FLASH:
              begin
                state_r <= mmtr_pkg::MMTR_PICKUP;
                target_r <= firstSetpoint_r;
                phasePulse_r <= 1'b1;
                contact_r <= 1'b1;
              end
              default:
              begin
                state_r <= mmtr_pkg::MMTR_PICKUP;
                target_r <= sp1;
              end
            endcase
          end
        end
        mmtr_pkg::MMTR_PICKUP:
        begin
          if (mode == mmtr_pkg::MMTR_PULSE)
          begin
            // Runs on regardless of trigger
            if (done)
            begin
              state_r <= mmtr_pkg::MMTR_IDLE;
              contact_r <= 1'b0;
              elapsed_r <= 17'h00000;
            end
            else if (tick_r && !hold)
              elapsed_r <= elapsed_r + 17'h00001;
          end
          else if (mode == mmtr_pkg::MMTR_FLASH)
          begin
            if (!trig)
            begin
              state_r <= mmtr_pkg::MMTR_IDLE;
              contact_r <= 1'b0;
              elapsed_r <= 17'h00000;
            end
            else if (done)
            begin
              // Swap phase; pulse and pause lengths independent
              phasePulse_r <= ~phasePulse_r;
              contact_r <= ~phasePulse_r;
              target_r <= phasePulse_r ? secondSetpoint_r : firstSetpoint_r;
              elapsed_r <= 17'h00000;
            end
            else if (tick_r && !hold)
              elapsed_r <= elapsed_r + 17'h00001;
          end
          else if (!trig)
          begin
            state_r <= mmtr_pkg::MMTR_IDLE;
            elapsed_r <= 17'h00000;
          end
          else if (done)
          begin
            state_r <= mmtr_pkg::MMTR_CLOSED;
            contact_r <= 1'b1;
            elapsed_r <= 17'h00000;
          end
          else if (tick_r && !hold)
            elapsed_r <= elapsed_r + 17'h00001;
        end
        mmtr_pkg::MMTR_CLOSED:
        begin
          // Hold has no effect here
          contact_r <= 1'b1;
          if (!trig)
          begin
            if (mode == mmtr_pkg::MMTR_ON_DELAY)
            begin
              state_r <= mmtr_pkg::MMTR_IDLE;
              contact_r <= 1'b0;
            end
            else
            begin
              state_r <= mmtr_pkg::MMTR_DROPOUT;
              target_r <= (mode == mmtr_pkg::MMTR_ON_OFF) ? sp2 : sp1;
              elapsed_r <= 17'h00000;
            end
          end
        end
        mmtr_pkg::MMTR_DROPOUT:
        begin
          if (trig)
          begin
            state_r <= mmtr_pkg::MMTR_CLOSED;
            elapsed_r <= 17'h00000;
          end
          else if (done)
          begin
            state_r <= mmtr_pkg::MMTR_IDLE;
            contact_r <= 1'b0;
            elapsed_r <= 17'h00000;
          end
          else if (tick_r && !hold)
            elapsed_r <= elapsed_r + 17'h00001;
        end
        default:
          state_r <= mmtr_pkg::MMTR_IDLE;
      endcase
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  logic access, known;
  assign access = psel & penable & ~pready_r;
  assign known = (paddr == mmtr_pkg::CTRL_OFFS) || (paddr == mmtr_pkg::SP1_OFFS) ||
                 (paddr == mmtr_pkg::SP2_OFFS) || (paddr == mmtr_pkg::STAT_OFFS) ||
                 (paddr == mmtr_pkg::ELAP_OFFS) || (paddr == mmtr_pkg::COIL_OFFS);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= mmtr_pkg::CTRL_RST;
      firstSetpoint_r <= mmtr_pkg::SP_RST;
      secondSetpoint_r <= mmtr_pkg::SP_RST;
      swCoil_r <= 3'h0;
    end
    else if (access && pwrite)
    begin
      case (paddr)
        mmtr_pkg::CTRL_OFFS: ctrl_r <= pwdata[6:0];
        mmtr_pkg::SP1_OFFS: firstSetpoint_r <= clampSp(pwdata);
        mmtr_pkg::SP2_OFFS: secondSetpoint_r <= clampSp(pwdata);
        mmtr_pkg::COIL_OFFS: swCoil_r <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= access;
      pslverr_r <= access & ~known;
      prdata_r <= 32'h00000000;
      if (access && !pwrite)
      begin
        case (paddr)
          mmtr_pkg::CTRL_OFFS: prdata_r <= {25'h0000000, ctrl_r};
          mmtr_pkg::SP1_OFFS: prdata_r <= {15'h0000, firstSetpoint_r};
          mmtr_pkg::SP2_OFFS: prdata_r <= {15'h0000, secondSetpoint_r};
          mmtr_pkg::STAT_OFFS:
            prdata_r <= {25'h0000000, clr, hold, trig, state_r, phasePulse_r, contact_r};
          mmtr_pkg::ELAP_OFFS: prdata_r <= {15'h0000, elapsed_r};
          mmtr_pkg::COIL_OFFS: prdata_r <= {29'h00000000, swCoil_r};
          default: prdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign contact = contact_r;
endmodule // mmtr_relay

// ---- bench/mmtr_ladder_model.sv ----
// Ladder logic stand-in driving the relay coils as levels
// Assumes the bench requests levels; coils change only after clk edges
`timescale 1ns/100ps
module mmtr_ladder_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requested levels
  input wire logic wantTrig,
  input wire logic wantHold,
  input wire logic wantClr,
  // Coils
  output logic triggerCoil,
  output logic holdCoil,
  output logic clearCoil
);
  // ************************************************************
  // Coil drive
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      triggerCoil <= 1'h0;
      holdCoil <= 1'h0;
      clearCoil <= 1'h0;
    end
    else
    begin
      triggerCoil <= wantTrig;
      holdCoil <= wantHold;
      clearCoil <= wantClr;
    end
  end
endmodule // mmtr_ladder_model

// ---- bench/mmtr_relay_assertions.sv ----
// Checker on the relay top ports
// Assumes written settings are shadowed from completed APB writes
`timescale 1ns/100ps
module mmtr_relay_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Coils and contact
  input wire logic triggerCoil,
  input wire logic holdCoil,
  input wire logic clearCoil,
  input wire logic contact
);
  // ************************************************************
  // Settings shadow
  // ************************************************************
  logic [6:0] ctrl_r;
  logic sp1Zero_r;
  logic [2:0] soft_r;
  logic [2:0] md;
  logic run;
  logic calm;
  assign md = ctrl_r[2:0];
  assign run = ctrl_r[mmtr_pkg::ENABLE_BIT];
  assign calm = run && soft_r == 3'h0 && !clearCoil && !holdCoil;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= mmtr_pkg::CTRL_RST;
      sp1Zero_r <= mmtr_pkg::SP_RST == 17'h0;
      soft_r <= 3'h0;
    end
    else if (psel && penable && pready && pwrite && !pslverr)
    begin
      if (paddr == mmtr_pkg::CTRL_OFFS)
        ctrl_r <= pwdata[6:0];
      if (paddr == mmtr_pkg::SP1_OFFS)
        sp1Zero_r <= pwdata == 32'h0;
      if (paddr == mmtr_pkg::COIL_OFFS)
        soft_r <= pwdata[2:0];
    end
  end
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_clearOpens; clearCoil [*4] |-> !contact; endproperty
  a_clearOpens: assert property (p_clearOpens)
    else $error("contact closed under clear");
  property p_onClose;
    (calm && md == mmtr_pkg::MMTR_ON_DELAY && sp1Zero_r && triggerCoil) [*8] |-> contact;
  endproperty
  a_onClose: assert property (p_onClose)
    else $error("on-delay did not close");
  property p_onOpen;
    (run && soft_r == 3'h0 && md == mmtr_pkg::MMTR_ON_DELAY && !triggerCoil) [*6] |-> !contact;
  endproperty
  a_onOpen: assert property (p_onOpen)
    else $error("on-delay closed without trigger");
  property p_offClose; (calm && md == mmtr_pkg::MMTR_OFF_DELAY && triggerCoil) [*6] |-> contact;
  endproperty
  a_offClose: assert property (p_offClose)
    else $error("off-delay open with trigger");
  property p_offExpire;
    (calm && md == mmtr_pkg::MMTR_OFF_DELAY && sp1Zero_r && !triggerCoil) [*8] |-> !contact;
  endproperty
  a_offExpire: assert property (p_offExpire)
    else $error("off-delay did not expire");
  property p_pairClose;
    (calm && md == mmtr_pkg::MMTR_ON_OFF && sp1Zero_r && triggerCoil) [*8] |-> contact;
  endproperty
  a_pairClose: assert property (p_pairClose)
    else $error("combined pick-up missing");
  property p_pulseEnds;
    (calm && md == mmtr_pkg::MMTR_PULSE && sp1Zero_r && triggerCoil) [*8] |-> !contact;
  endproperty
  a_pulseEnds: assert property (p_pulseEnds)
    else $error("pulse outlived its time");
  property p_stopOpen; (!run) [*4] |-> !contact; endproperty
  a_stopOpen: assert property (p_stopOpen)
    else $error("contact closed in stop");
endmodule // mmtr_relay_checker
bind mmtr_relay mmtr_relay_checker mmtr_relay_checker_inst (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .triggerCoil(triggerCoil), .holdCoil(holdCoil),
  .clearCoil(clearCoil), .contact(contact));

// ---- bench/mmtr_relay_tb_top.sv ----
// Self-checking bench: APB tasks and coil scenarios with zero setpoints
// Assumes the ladder stand-in model and the bound checker
`timescale 1ns/100ps
module mmtr_relay_tb_top;
  // ************************************************************
  // Signals, instances, tasks
  // ************************************************************
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, prev;
  logic triggerCoil, holdCoil, clearCoil, contact, wantTrig, wantHold, wantClr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int fails, testsRun, n;
  mmtr_relay mmtr_relay_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .triggerCoil(triggerCoil), .holdCoil(holdCoil),
    .clearCoil(clearCoil), .contact(contact));
  mmtr_ladder_model mmtr_ladder_model_inst (.clk(clk), .rst_n(rst_n), .wantTrig(wantTrig),
    .wantHold(wantHold), .wantClr(wantClr), .triggerCoil(triggerCoil),
    .holdCoil(holdCoil), .clearCoil(clearCoil));
  initial
  begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  task automatic reportAndStop();
    $display("Checks %0d, mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    i = 0;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'h1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1)
    begin
      fails++;
      reportAndStop();
    end
    @(posedge clk);
  endtask
  task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkContact(input logic exp);
    chkWord("contact", {31'h0, exp}, {31'h0, contact});
  endtask
  task automatic coils(input logic t, input logic h, input logic c);
    wantTrig <= t;
    wantHold <= h;
    wantClr <= c;
    repeat (8) @(posedge clk);
  endtask
  task automatic cfg(input logic [2:0] m);
    apb(1'h1, mmtr_pkg::CTRL_OFFS, (32'h1 << mmtr_pkg::ENABLE_BIT) | {29'h0, m});
  endtask
  task automatic countRises(input int k);
    n = 0;
    prev = contact;
    repeat (k)
    begin
      @(posedge clk);
      if (contact === 1'h1 && prev !== 1'h1)
        n++;
      prev = contact;
    end
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    {rst_n, psel, penable, pwrite, wantTrig, wantHold, wantClr} = 7'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    testsRun = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    apb(1'h0, mmtr_pkg::CTRL_OFFS, 32'h0);
    chkWord("ctrl reset", {25'h0, mmtr_pkg::CTRL_RST}, rd);
    apb(1'h0, 8'h18, 32'h0);
    chkWord("unmapped error", 32'h1, {31'h0, err});
    apb(1'h1, mmtr_pkg::SP1_OFFS, 32'hFFFFF);
    apb(1'h0, mmtr_pkg::SP1_OFFS, 32'h0);
    chkWord("setpoint clamp", {15'h0, mmtr_pkg::SP_MAX}, rd);
    apb(1'h1, mmtr_pkg::SP1_OFFS, 32'h0);
    $display("Test registers done");
    cfg(mmtr_pkg::MMTR_ON_DELAY);
    coils(1'h1, 1'h0, 1'h0);
    chkContact(1'h1);
    coils(1'h1, 1'h1, 1'h0);
    chkContact(1'h1);
    coils(1'h1, 1'h0, 1'h1);
    chkContact(1'h0);
    coils(1'h1, 1'h0, 1'h0);
    chkContact(1'h1);
    coils(1'h0, 1'h0, 1'h0);
    chkContact(1'h0);
    apb(1'h1, mmtr_pkg::COIL_OFFS, 32'h1);
    coils(1'h0, 1'h0, 1'h0);
    chkContact(1'h1);
    apb(1'h1, mmtr_pkg::COIL_OFFS, 32'h0);
    coils(1'h0, 1'h0, 1'h0);
    chkContact(1'h0);
    $display("Test on-delay done");
    cfg(mmtr_pkg::MMTR_OFF_DELAY);
    coils(1'h1, 1'h0, 1'h0);
    chkContact(1'h1);
    coils(1'h1, 1'h1, 1'h0);
    coils(1'h0, 1'h1, 1'h0);
    chkContact(1'h1);
    coils(1'h0, 1'h0, 1'h0);
    chkContact(1'h0);
    coils(1'h1, 1'h1, 1'h0);
    coils(1'h0, 1'h1, 1'h0);
    coils(1'h0, 1'h1, 1'h1);
    chkContact(1'h0);
    coils(1'h0, 1'h0, 1'h0);
    $display("Test off-delay done");
    // Combined mode with random switching; zero setpoints draw zero
    apb(1'h1, mmtr_pkg::CTRL_OFFS, (32'h1 << mmtr_pkg::ENABLE_BIT) |
      (32'h1 << mmtr_pkg::RAND_BIT) | {29'h0, mmtr_pkg::MMTR_ON_OFF});
    coils(1'h1, 1'h0, 1'h0);
    chkContact(1'h1);
    coils(1'h1, 1'h1, 1'h0);
    chkContact(1'h1);
    coils(1'h0, 1'h0, 1'h0);
    chkContact(1'h0);
    $display("Test combined done");
    cfg(mmtr_pkg::MMTR_PULSE);
    wantTrig <= 1'h1;
    countRises(16);
    chkWord("pulse closings", 32'h1, n);
    chkContact(1'h0);
    coils(1'h0, 1'h0, 1'h0);
    $display("Test pulse done");
    cfg(mmtr_pkg::MMTR_FLASH);
    wantTrig <= 1'h1;
    // Zero phases toggle every cycle: only the first closing fits in 5
    countRises(5);
    chkWord("flash first phase", 32'h1, n);
    countRises(40);
    chkWord("flash repeats", 32'h1, {31'h0, n >= 2});
    coils(1'h1, 1'h0, 1'h1);
    chkContact(1'h0);
    coils(1'h0, 1'h0, 1'h0);
    chkContact(1'h0);
    $display("Test flash done");
    // Retentive on-delay: restart in run with trigger high, no new edge
    apb(1'h1, mmtr_pkg::CTRL_OFFS, (32'h1 << mmtr_pkg::ENABLE_BIT) |
      (32'h1 << mmtr_pkg::RETAIN_BIT));
    coils(1'h1, 1'h0, 1'h0);
    chkContact(1'h1);
    apb(1'h1, mmtr_pkg::CTRL_OFFS, 32'h1 << mmtr_pkg::RETAIN_BIT);
    coils(1'h1, 1'h0, 1'h0);
    chkContact(1'h0);
    apb(1'h1, mmtr_pkg::CTRL_OFFS, (32'h1 << mmtr_pkg::ENABLE_BIT) |
      (32'h1 << mmtr_pkg::RETAIN_BIT));
    coils(1'h1, 1'h0, 1'h0);
    chkContact(1'h1);
    coils(1'h0, 1'h0, 1'h0);
    $display("Test retentive done");
    reportAndStop();
  end
endmodule // mmtr_relay_tb_top
